//--- src/msq_acc.sv
// Up/down results counter with per-phase step
`timescale 1ns/1ps
module msq_acc (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Control and value
    msq_acc_if.acc    acc
);
    import msq_pkg::*;
    logic [ACC_W-1:0] step;

    // Step weight in eighths: 64, 8, 1, 1/8 counts
    assign step = {{(ACC_W-10){1'b0}}, STEP[acc.step_sel]};

    // Clear wins; direction set by deintegrate polarity
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            acc.value <= '0;
        end else if (acc.clr) begin
            acc.value <= '0;
        end else if (acc.en) begin
            acc.value <= acc.up ? acc.value + step : acc.value - step;
        end
    end
endmodule // msq_acc

//--- src/msq_acc_if.sv
// Interface: results counter control and value
`timescale 1ns/1ps
interface msq_acc_if;
    logic                      clr;
    logic                      en;
    logic                      up;
    logic [1:0]                step_sel;
    logic [msq_pkg::ACC_W-1:0] value;
    modport ctl (output clr, output en, output up, output step_sel, input value);
    modport acc (input clr, input en, input up, input step_sel, output value);
endinterface

//--- src/msq_pkg.sv
// Package: constants for the multi-slope converter sequencer
package msq_pkg;
    // Sequence counter
    localparam int             CNT_W      = 11;
    localparam logic [10:0]    CNT_IDLE   = 11'h000;
    localparam logic [10:0]    CNT_FIRST  = 11'h001;
    localparam logic [10:0]    CNT_LAST   = 11'h71B;  // 1819, 1820 counts
    // Zero-integrate lead-in and integrate lengths
    localparam logic [10:0]    ZI_PRE_60  = 11'h06F;  // 111 clocks
    localparam logic [10:0]    ZI_PRE_50  = 11'h001;  // 1 clock
    localparam logic [10:0]    INT_LEN_60 = 11'h221;  // 545 counts
    localparam logic [10:0]    INT_LEN_50 = 11'h28F;  // 655 counts
    localparam logic [10:0]    ZI_POST    = 11'h014;  // 20 closing clocks
    // Deintegrate windows (start, max end), index 0 = first phase
    localparam logic [3:0][10:0] DW_START = {11'h661, 11'h5C1, 11'h529, 11'h291};
    localparam logic [3:0][10:0] DW_END   = {11'h707, 11'h650, 11'h5B0, 11'h510};
    // Results counter, in eighths of a count
    localparam int             ACC_W      = 21;
    localparam int             RES_W      = 19;
    localparam logic [3:0][9:0] STEP      = {10'h001, 10'h008, 10'h040, 10'h200};
    // Start bit self-clear
    localparam logic [2:0]     START_HOLD = 3'h5;
    // Command register bit positions
    localparam int             CMD_START  = 7;
    localparam int             CMD_50HZ   = 6;
    localparam int             CMD_SLEEP  = 5;
    localparam int             CMD_ZERO   = 4;
    localparam int             CMD_SEL_LO = 2;
    localparam int             CMD_SEL_HI = 1;
    // Register select codes {reg_select_high, reg_select_low}
    localparam logic [1:0]     SEL_OUT0   = 2'h0;
    localparam logic [1:0]     SEL_OUT1   = 2'h1;
    localparam logic [1:0]     SEL_STAT   = 2'h2;
    localparam logic [7:0]     RD_INVALID = 8'h00;
    // Status bit positions
    localparam int             ST_CLASH   = 7;
    localparam int             ST_EOC     = 6;
    localparam int             ST_INTEG   = 5;
    localparam int             ST_SLEEP   = 4;
    localparam int             ST_LOW     = 3;
    localparam logic [7:0]     CMD_RESET  = 8'h00;
    localparam logic [11:0]    PIN_IDLE   = 12'h007;  // cs_n, rd_n, wr_n high
    // Conversion phases
    typedef enum logic [2:0] {
        PH_ZERO, PH_INTEG, PH_DEINT, PH_REST, PH_TIMES_EIGHT
    } msq_phase_e;
endpackage

//--- src/msq_seq.sv
// Multi-slope converter sequencer, results and status readout
`timescale 1ns/1ps
module msq_seq (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Parallel bus pins
    input  wire logic       cs_n,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    input  wire logic [7:0] d_in,
    output logic      [7:0] d_out,
    output logic            d_oe,
    // Comparator, high when integrator is positive
    input  wire logic       comp,
    // Analog switch controls
    output logic            sw_zero,
    output logic            sw_integ,
    output logic            sw_deint_pos,
    output logic            sw_deint_neg,
    output logic            sw_rest,
    output logic            sw_times_eight,
    output logic            sw_short_in,
    // Status lines
    output logic            eoc,
    output logic            osc_stop
);
    import msq_pkg::*;

    // Synchronised pins
    logic [11:0]      pins;
    logic [11:0]      pins_s;
    logic             cs_s;
    logic             rd_s;
    logic             wr_s;
    logic [7:0]       d_s;
    logic             comp_s;
    // Command register
    logic             start_q;
    logic [2:0]       start_age_q;
    logic             f50_q;
    logic             sleep_cmd_q;
    logic             zero_q;
    logic [1:0]       sel_q;
    // Sequencer state
    logic [CNT_W-1:0] cnt_q;
    logic             conv50_q;
    logic             dir_q;
    logic             deint_on_q;
    logic [1:0]       win_q;
    logic             sleep_q;
    // Bus tracking
    logic             wr_prev_q;
    logic             rd_prev_q;
    logic             clash_q;
    logic [RES_W-1:0] res_q;
    // Decodes
    logic             begin_conv;
    logic             wr_take;
    logic             rd_act;
    logic             rd_end;
    logic             xfer;
    logic [10:0]      int_start;
    logic [10:0]      int_end;
    logic             in_integ;
    logic             in_win;
    logic             in_times_eight;
    logic             win_open;
    logic             win_close;
    logic [1:0]       win_idx;
    msq_phase_e       phase;
    logic [7:0]       rd_mux;

    msq_acc_if acc_bus ();

    // Pins from outside the clock domain
    assign pins = {d_in, comp, wr_n, rd_n, cs_n};
    genvar gi;
    generate
        for (gi = 0; gi < 12; gi++) begin : g_sync
            msq_sync #(.RST(PIN_IDLE[gi])) u_sync (
                .clk   (clk),
                .rst_n (rst_n),
                .pin   (pins[gi]),
                .level (pins_s[gi])
            );
        end
    endgenerate
    assign cs_s   = pins_s[0];
    assign rd_s   = pins_s[1];
    assign wr_s   = pins_s[2];
    assign comp_s = pins_s[3];
    assign d_s    = pins_s[11:4];

    // Bus strobes
    assign wr_take = wr_s && !wr_prev_q && !cs_s;
    assign rd_act  = !cs_s && !rd_s;
    assign rd_end  = rd_s && !rd_prev_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_prev_q <= 1'b1;
            rd_prev_q <= 1'b1;
        end else begin
            wr_prev_q <= wr_s;
            rd_prev_q <= rd_s || cs_s;
        end
    end

    // Command register; start self-clears, a new write wins
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            start_q     <= CMD_RESET[CMD_START];
            f50_q       <= CMD_RESET[CMD_50HZ];
            sleep_cmd_q <= CMD_RESET[CMD_SLEEP];
            zero_q      <= CMD_RESET[CMD_ZERO];
            sel_q       <= SEL_OUT0;
        end else if (wr_take) begin
            start_q     <= d_s[CMD_START];
            f50_q       <= d_s[CMD_50HZ];
            sleep_cmd_q <= d_s[CMD_SLEEP];
            zero_q      <= d_s[CMD_ZERO];
            sel_q       <= {d_s[CMD_SEL_HI], d_s[CMD_SEL_LO]};
        end else if (start_age_q == START_HOLD) begin
            start_q     <= 1'b0;
        end
    end

    // Start bit is checked only at the idle count
    assign begin_conv = (cnt_q == CNT_IDLE) && start_q && !sleep_q;

    // Age of the start bit since the conversion took it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            start_age_q <= '0;
        end else if (begin_conv) begin
            start_age_q <= 3'h1;
        end else if (start_age_q != '0 && start_age_q != START_HOLD) begin
            start_age_q <= start_age_q + 3'h1;
        end else begin
            start_age_q <= '0;
        end
    end

    // Sequence counter: idles at zero, runs 1820 counts
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= CNT_IDLE;
        end else if (cnt_q == CNT_IDLE) begin
            cnt_q <= begin_conv ? CNT_FIRST : CNT_IDLE;
        end else if (cnt_q == CNT_LAST) begin
            cnt_q <= CNT_IDLE;
        end else begin
            cnt_q <= cnt_q + 11'h001;
        end
    end

    // Line frequency held for the whole conversion
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            conv50_q <= 1'b0;
        end else if (begin_conv) begin
            conv50_q <= f50_q;
        end
    end

    // Both modes end integration at the same count
    assign int_start = conv50_q ? ZI_PRE_50 + 11'h001 : ZI_PRE_60 + 11'h001;
    assign int_end   = conv50_q ? ZI_PRE_50 + INT_LEN_50 : ZI_PRE_60 + INT_LEN_60;
    assign in_integ  = (cnt_q >= int_start) && (cnt_q <= int_end);

    // Window decode over the four deintegrate slots
    always_comb begin
        in_win    = 1'b0;
        in_times_eight = 1'b0;
        win_open  = 1'b0;
        win_close = 1'b0;
        win_idx   = 2'h0;
        for (int k = 0; k < 4; k++) begin
            if (cnt_q >= DW_START[k] && cnt_q <= DW_END[k]) begin
                in_win  = 1'b1;
                win_idx = 2'(k);
            end
            if (cnt_q + 11'h001 == DW_START[k]) begin
                win_open = 1'b1;
                win_idx  = 2'(k);
            end
            if (cnt_q == DW_END[k]) begin
                win_close = 1'b1;
            end
            // Times-eight fills the gap before windows two to four
            if (k > 0 && cnt_q > DW_END[k-1] && cnt_q < DW_START[k]) begin
                in_times_eight = 1'b1;
            end
        end
    end

    // Polarity sample at integrate end and at the end of windows one to three
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dir_q <= 1'b0;
        end else if (cnt_q == int_end || (win_close && win_idx != 2'h3)) begin
            dir_q <= comp_s;
        end
    end

    // Deintegrate runs from window start to crossing or maximum
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            deint_on_q <= 1'b0;
            win_q      <= 2'h0;
        end else if (win_open) begin
            deint_on_q <= 1'b1;
            win_q      <= win_idx;
        end else if (deint_on_q && (comp_s != dir_q || win_close)) begin
            deint_on_q <= 1'b0;
        end
    end

    // Present phase; crossing cycle still deintegrates
    always_comb begin
        if (in_integ) begin
            phase = PH_INTEG;
        end else if (in_win && deint_on_q) begin
            phase = PH_DEINT;
        end else if (in_win) begin
            phase = PH_REST;
        end else if (in_times_eight) begin
            phase = PH_TIMES_EIGHT;
        end else begin
            phase = PH_ZERO;
        end
    end

    // Switch drive from phase and deintegrate polarity
    always_comb begin
        sw_zero      = 1'b0;
        sw_integ     = 1'b0;
        sw_deint_pos = 1'b0;
        sw_deint_neg = 1'b0;
        sw_rest      = 1'b0;
        sw_times_eight = 1'b0;
        case (phase)
            PH_ZERO:  sw_zero = 1'b1;
            PH_INTEG: sw_integ = 1'b1;
            PH_DEINT: begin
                sw_deint_pos = dir_q;
                sw_deint_neg = !dir_q;
            end
            PH_REST:  sw_rest = 1'b1;
            PH_TIMES_EIGHT: sw_times_eight = 1'b1;
            default:  sw_zero = 1'b1;
        endcase
    end
    assign sw_short_in = zero_q;

    // Results counter drive
    assign acc_bus.clr      = begin_conv;
    assign acc_bus.en       = (phase == PH_DEINT);
    assign acc_bus.up       = dir_q;
    assign acc_bus.step_sel = win_q;

    msq_acc u_acc (
        .clk   (clk),
        .rst_n (rst_n),
        .acc   (acc_bus)
    );

    // Transfer at the last count, as the counter returns to idle
    assign xfer = (cnt_q == CNT_LAST);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            res_q <= '0;
        end else if (xfer) begin
            res_q <= acc_bus.value[RES_W-1:0];
        end
    end

    // Clash flag: a new result under a read sets, set beats clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            clash_q <= 1'b0;
        end else if (xfer && rd_act) begin
            clash_q <= 1'b1;
        end else if (rd_end && sel_q == SEL_STAT) begin
            clash_q <= 1'b0;
        end
    end

    // Sleep entered only with the conversion complete
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sleep_q <= 1'b0;
        end else begin
            sleep_q <= sleep_cmd_q && (cnt_q == CNT_IDLE);
        end
    end

    // Read data select; eighths sit in the status low bits
    always_comb begin
        case (sel_q)
            SEL_OUT0: rd_mux = res_q[10:3];
            SEL_OUT1: rd_mux = {res_q[RES_W-1], res_q[17:11]};
            SEL_STAT: begin
                rd_mux           = {5'h00, res_q[2:0]};
                rd_mux[ST_CLASH] = clash_q;
                rd_mux[ST_EOC]   = (cnt_q == CNT_IDLE);
                rd_mux[ST_INTEG] = in_integ;
                rd_mux[ST_SLEEP] = sleep_q;
                rd_mux[ST_LOW]   = 1'b0;
            end
            default:  rd_mux = RD_INVALID;
        endcase
    end

    // Registered bus drive; data reload from the select every cycle, during a read too
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            d_out    <= '0;
            d_oe     <= 1'b0;
            eoc      <= 1'b1;
            osc_stop <= 1'b0;
        end else begin
            d_out    <= rd_mux;
            d_oe     <= rd_act;
            eoc      <= (cnt_q == CNT_IDLE);
            osc_stop <= sleep_q;
        end
    end
endmodule // msq_seq

//--- src/msq_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module msq_sync #(
    parameter logic RST = 1'b0
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Pin and clean level
    input  wire logic pin,
    output logic      level
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    // First stage feeds only the second
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_q <= RST;
            s2_q <= RST;
            s3_q <= RST;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Change counts once stages two and three agree
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            level <= RST;
        end else if (s2_q == s3_q) begin
            level <= s3_q;
        end
    end
endmodule // msq_sync

//--- verif/msq_host.sv
// Host model: drives the converter's parallel bus pins
`timescale 1ns/1ps
module msq_host (
    // Clock
    input  wire logic       clk,
    // Bus pins
    output logic            cs_n,
    output logic            rd_n,
    output logic            wr_n,
    output wire logic [7:0] d_in,
    input  wire logic [7:0] d_out,
    input  wire logic       d_oe
);
    logic       drv = 1'b0;
    logic [7:0] wd = 8'h00;
    logic [7:0] flt = 8'h5A;
    initial {cs_n, rd_n, wr_n} = 3'h7;
    // Released bus shows a changing pattern, never a stale value
    always @(negedge clk) flt <= ~flt;
    assign d_in = d_oe ? d_out : (drv ? wd : flt);
    // Command write; strobes long enough for the pin synchroniser
    task automatic cmd(input logic st, f, sl, z, input logic [1:0] sel);
        @(negedge clk);
        wd = {st, f, sl, z, 1'b0, sel[0], sel[1], 1'b0};
        drv = 1'b1;
        cs_n = 1'b0;
        wr_n = 1'b0;
        repeat (4) @(negedge clk);
        wr_n = 1'b1;
        repeat (3) @(negedge clk);
        cs_n = 1'b1;
        drv = 1'b0;
        repeat (4) @(negedge clk);
    endtask
    // Read cycle; data taken once the device drives
    task automatic get(input int h, output logic [7:0] v);
        int t;
        t = 0;
        @(negedge clk);
        cs_n = 1'b0;
        rd_n = 1'b0;
        while (d_oe !== 1'b1 && t < 12) begin
            @(negedge clk);
            t++;
        end
        @(negedge clk);
        v = d_out;
        repeat (h) @(negedge clk);
        rd_n = 1'b1;
        cs_n = 1'b1;
        repeat (6) @(negedge clk);
    endtask
endmodule // msq_host

//--- verif/msq_seq_monitor.sv
// Checker: phase timing relations seen at the sequencer pins
`timescale 1ns/1ps
module msq_seq_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bus strobes
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic d_oe,
    // Analog side
    input wire logic comp,
    input wire logic sw_zero,
    input wire logic sw_integ,
    input wire logic sw_deint_pos,
    input wire logic sw_deint_neg,
    input wire logic sw_rest,
    input wire logic sw_times_eight,
    input wire logic eoc
);
    logic [10:0] cl_q, zr_q, lz_q, ld_q, ir_q;
    logic [1:0]  xn_q;
    logic        deint;
    assign deint = sw_deint_pos | sw_deint_neg;
    // Run lengths of phases restart whenever the phase drops; ld_q keeps the lead-in, xn_q counts times-eight phases
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            {cl_q, zr_q, lz_q, ld_q, ir_q} <= '0;
            xn_q <= 2'h0;
        end else begin
            cl_q <= eoc ? 11'h000 : cl_q + 11'h001;
            zr_q <= sw_zero ? zr_q + 11'h001 : 11'h000;
            lz_q <= (sw_zero && !eoc) ? lz_q + 11'h001 : 11'h000;
            ir_q <= sw_integ ? ir_q + 11'h001 : 11'h000;
            if ($rose(sw_integ)) ld_q <= lz_q;
            if ($rose(sw_times_eight)) xn_q <= xn_q + 2'h1;
            else if (eoc) xn_q <= 2'h0;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_one_sw;
        $onehot({sw_zero, sw_integ, sw_deint_pos, sw_deint_neg, sw_rest, sw_times_eight});
    endproperty
    a_one_sw: assert property (p_one_sw) else $error("switch decode not one-hot");
    property p_idle;
        eoc && $past(eoc) |-> sw_zero;
    endproperty
    a_idle: assert property (p_idle) else $error("idle without zero-integrate");
    property p_conv_len;
        $rose(eoc) |-> cl_q == 11'h71B;
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
    property p_post;
        $rose(eoc) |-> zr_q == 11'h015;
    endproperty
    a_post: assert property (p_post) else $error("closing zero run wrong");
    property p_lead;
        $rose(sw_integ) |-> lz_q == 11'h06E || lz_q == 11'h000;
    endproperty
    a_lead: assert property (p_lead) else $error("lead-in zero run wrong");
    property p_integ;
        $fell(sw_integ) |-> (ir_q == 11'h221 && ld_q == 11'h06E)
                         || (ir_q == 11'h28F && ld_q == 11'h000);
    endproperty
    a_integ: assert property (p_integ) else $error("integrate length wrong");
    property p_first_pol;
        // Polarity as it stood in the last integrate cycle; a fast crossing may flip it now
        $fell(sw_integ) |-> sw_deint_pos == $past(comp) && sw_deint_neg == !$past(comp);
    endproperty
    a_first_pol: assert property (p_first_pol) else $error("first direction wrong");
    property p_rest;
        $fell(deint) |-> sw_rest;
    endproperty
    a_rest: assert property (p_rest) else $error("no rest after crossing");
    property p_mul8;
        $fell(sw_times_eight) |-> deint;
    endproperty
    a_mul8: assert property (p_mul8) else $error("times-eight not followed by deint");
    property p_mul8_cnt;
        $rose(eoc) |-> xn_q == 2'h3;
    endproperty
    a_mul8_cnt: assert property (p_mul8_cnt) else $error("times-eight count wrong");
    property p_oe;
        (!cs_n && !rd_n) [*7] |-> d_oe;
    endproperty
    a_oe: assert property (p_oe) else $error("read not driven");
    c_end: cover property ($rose(eoc));
    c_mul8: cover property ($fell(sw_times_eight));
    c_read: cover property ($rose(d_oe));
endmodule // msq_seq_monitor
bind msq_seq msq_seq_monitor i_mon (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .rd_n(rd_n),
    .d_oe(d_oe), .comp(comp), .sw_zero(sw_zero), .sw_integ(sw_integ),
    .sw_deint_pos(sw_deint_pos), .sw_deint_neg(sw_deint_neg), .sw_rest(sw_rest),
    .sw_times_eight(sw_times_eight), .eoc(eoc));

//--- verif/msq_seq_tb.sv
// Testbench: conversions, result steps, status bits and collisions
`timescale 1ns/1ps
module msq_seq_tb;
    import msq_pkg::*;
    logic        clk, rst_n, comp, pol, f, sl, z, cs_n, rd_n, wr_n, d_oe, eoc;
    logic        osc_stop, sw_short_in, sw_zero, sw_integ, sw_deint_pos;
    logic        sw_deint_neg, sw_rest, sw_times_eight;
    logic [7:0]  d_in, d_out, a, s;
    logic [18:0] r0, r1, dr;
    int          seed = 74, miscompares, checks_done, cyc, dk, dc;
    int          nd [5];
    msq_seq i_dut (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
        .d_in(d_in), .d_out(d_out), .d_oe(d_oe), .comp(comp), .sw_zero(sw_zero),
        .sw_integ(sw_integ), .sw_deint_pos(sw_deint_pos), .sw_deint_neg(sw_deint_neg),
        .sw_rest(sw_rest), .sw_times_eight(sw_times_eight), .sw_short_in(sw_short_in), .eoc(eoc),
        .osc_stop(osc_stop));
    msq_host i_host (.clk(clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .d_in(d_in),
        .d_out(d_out), .d_oe(d_oe));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Integrator: crosses zero nd[k] clocks into deintegrate k
    always @(negedge clk) begin
        if (sw_integ) begin
            comp = pol;
            dk = 0;
            dc = 0;
        end else if (sw_deint_pos | sw_deint_neg) begin
            dc++;
            if (dc == nd[dk]) comp = ~comp;
        end else if (dc != 0) begin
            dk++;
            dc = 0;
        end
    end
    // Hang guard, well above the total run length
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            miscompares++;
            results();
        end
    end
    task automatic chk(input logic [18:0] g, input logic [18:0] e);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Expected result change for one extra clock in deintegrate phase k, in eighths
    function automatic logic [18:0] exp_step(input int k);
        return 19'(STEP[k]);
    endfunction
    task automatic results();
        $display("checks=%0d mismatches=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic st, input logic [1:0] sel);
        i_host.cmd(st, f, sl, z, sel);
    endtask
    task automatic rd(input logic [1:0] sel, input int h, output logic [7:0] v);
        wr(1'b0, sel);
        i_host.get(h, v);
    endtask
    // Bounded wait for the completion line
    task automatic weoc(input logic v);
        int t;
        t = 0;
        while (eoc !== v && t < 2500) begin
            @(negedge clk);
            t++;
        end
        if (t == 2500) miscompares++;
    endtask
    // One conversion, optionally polling the integrating bit
    task automatic conv(input logic poll, output logic [18:0] r);
        logic [7:0] b;
        wr(1'b1, SEL_OUT0);
        weoc(1'b0);
        if (poll) begin
            repeat (150) @(negedge clk);
            rd(SEL_STAT, 2, s);
            chk(19'(s[6:5]), 19'h1);
            repeat (600) @(negedge clk);
            rd(SEL_STAT, 2, s);
            chk(19'(s[5]), 19'h0);
        end
        weoc(1'b1);
        rd(SEL_OUT0, 2, a);
        rd(SEL_OUT1, 2, b);
        rd(SEL_STAT, 2, s);
        chk(19'(s[7:6]), 19'h1);
        r = {b, a, s[2:0]};
    endtask
    initial begin
        rst_n = 1'b0;
        comp = 1'b0;
        {pol, f, sl, z} = 4'h0;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        chk(19'({eoc, sw_zero, d_oe, osc_stop}), 19'hC);
        rd(SEL_STAT, 2, s);
        chk(19'(s[6:3]), 19'h8);
        rd(2'h3, 2, s);
        chk(19'(s), 19'(RD_INVALID));
        $display("test idle done");
        // Pairs differing by one clock in one deintegrate phase
        for (int k = 0; k < 4; k++) begin
            f = 1'(k);  // Alternate so both line frequencies always run
            pol = 1'($random(seed));
            for (int i = 0; i < 4; i++) nd[i] = 1 + {$random(seed)} % 30;
            conv(k == 0, r0);
            nd[k] = nd[k] + 1;
            conv(1'b0, r1);
            dr = r1 - r0;
            if (dr[18]) dr = -dr;
            chk(dr, exp_step(k));
            $display("test step %0d done", k);
        end
        // Result transfer while output register 0 is being read
        wr(1'b1, SEL_OUT0);
        weoc(1'b0);
        repeat (1770) @(negedge clk);
        rd(SEL_OUT0, 50, a);
        rd(SEL_STAT, 2, s);
        chk(19'(s[7]), 19'h1);
        rd(SEL_STAT, 2, s);
        chk(19'(s[7]), 19'h0);
        $display("test clash done");
        // Start written mid-conversion runs once more, then stops
        wr(1'b1, SEL_STAT);
        weoc(1'b0);
        repeat (20) @(negedge clk);
        wr(1'b1, SEL_STAT);
        weoc(1'b1);
        repeat (4) @(negedge clk);
        chk(19'(eoc), 19'h0);
        weoc(1'b1);
        repeat (40) @(negedge clk);
        chk(19'(eoc), 19'h1);
        $display("test restart done");
        // Sleep requested mid-conversion waits for completion
        wr(1'b1, SEL_STAT);
        weoc(1'b0);
        sl = 1'b1;
        wr(1'b0, SEL_STAT);
        chk(19'(osc_stop), 19'h0);
        weoc(1'b1);
        repeat (10) @(negedge clk);
        chk(19'(osc_stop), 19'h1);
        rd(SEL_STAT, 2, s);
        chk(19'(s[6:4]), 19'h5);
        sl = 1'b0;
        z = 1'b1;
        wr(1'b0, SEL_STAT);
        chk(19'({osc_stop, sw_short_in}), 19'h1);
        $display("test sleep done");
        results();
    end
endmodule // msq_seq_tb
